// ===== pkg/vcs_pkg.sv
// Function
// - Automatic mode captures on trigger, then counts down to each next capture until triggered again.
// - Interval bits 9:8 pick unit: 00 seconds, 01 minutes, 10 hours.
// - Interval bits 7:0 times the unit give the automatic capture spacing.
// - Automatic plus power-down captures, sleeps, and the countdown keeps running.
// - Event mode trigger starts circular sampling, checking each sample against alarms.
// - Pre-event circular length comes from setup bits 5:4.
// - Pre-event code 00/01/10/11 means 64/128/256/512 samples.
// - An alarm crossing fills the rest of the buffer, then ends the capture.
// - Alarm trips when sample magnitude exceeds the twos complement threshold.
// - Extended mode is manual capture of one axis across all three buffers.
// - Extended order: first 1024 to x, next to y, last to z buffer.
// - Mode 11 in bits 3:2 selects extended; bits 9:8 pick the axis.
// - Axis code 00 x, 01 y, 10 z, 11 reserved.
// - Setup bit 1 puts the device to sleep after each completed capture.
// - Chip select going low wakes a sleeping device.
// - A rising edge on a trigger-configured digital pin also wakes the device.
// - Frames during wake recovery are dropped; host re-frames chip select to resume.
// - Once awake, stay awake until next capture completes or sleep command.
// - Command bit 1 puts the device to sleep.
// - Setup bit 6 mirrors buffers to nonvolatile store right after capture.
// - Command bit 13 restores the nonvolatile mirror into the buffers.
// - Capture time is 0.014 s plus sample term; 0.516 s with mirroring.
package vcs_pkg;
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int SECOND_S = 1;
  localparam int SEC_CYCLES = SECOND_S * CLK_FREQ_HZ;
  localparam real WAKE_RECOVERY_MS = 2.5;
  localparam int WAKE_CYCLES =
    int'($ceil(WAKE_RECOVERY_MS * 1.0e-3 * CLK_FREQ_HZ));
  localparam real CAPT_FIXED_S = 0.014;
  localparam real CAPT_FLASH_FIXED_S = 0.516;
  localparam int FLASH_CYCLES =
    int'($ceil((CAPT_FLASH_FIXED_S - CAPT_FIXED_S) * CLK_FREQ_HZ));
  localparam int SECS_PER_MIN = 60;
  localparam int SECS_PER_HOUR = 3600;
  localparam int BUF_DEPTH = 1024;
  localparam int EXT_DEPTH = 3 * BUF_DEPTH;
  localparam int PRE_MIN = 64;
  localparam int FRAME_BITS = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int AVG_W = 4;
  // Byte addresses (low byte of each word)
  localparam logic [6:0] ADDR_CAPTURE_SETUP = 7'h1c;
  localparam logic [6:0] ADDR_CAPTURE_INTERVAL = 7'h1e;
  localparam logic [6:0] ADDR_X_ALARM = 7'h20;
  localparam logic [6:0] ADDR_Y_ALARM = 7'h22;
  localparam logic [6:0] ADDR_Z_ALARM = 7'h24;
  localparam logic [6:0] ADDR_ALARM_SETUP = 7'h28;
  localparam logic [6:0] ADDR_PIN_SETUP = 7'h36;
  localparam logic [6:0] ADDR_AVG_COUNT = 7'h38;
  localparam logic [6:0] ADDR_STATUS = 7'h3a;
  localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h3e;
  // Field positions
  localparam int SETUP_PD_BIT = 1;
  localparam int SETUP_MODE_LSB = 2;
  localparam int SETUP_PRE_LSB = 4;
  localparam int SETUP_FLASH_BIT = 6;
  localparam int SETUP_AXIS_LSB = 8;
  localparam int INTERVAL_UNIT_LSB = 8;
  localparam int CMD_SLEEP_BIT = 1;
  localparam int CMD_TRIGGER_BIT = 11;
  localparam int CMD_RESTORE_BIT = 13;
  localparam int PIN_ONE_TRIG_BIT = 0;
  localparam int PIN_TWO_TRIG_BIT = 1;
  // Reset values
  localparam logic [15:0] CAPTURE_SETUP_RST = 16'h0020;
  localparam logic [15:0] CAPTURE_INTERVAL_RST = 16'h0000;
  localparam logic [15:0] ALARM_RST = 16'h0000;
  localparam logic [15:0] PIN_SETUP_RST = 16'h0000;
  localparam logic [15:0] AVG_COUNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_EVENT = 2'b10,
    MODE_EXT = 2'b11
  } mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PRE = 5'b00010,
    ST_FILL = 5'b00100,
    ST_FLASH = 5'b01000,
    ST_COUNT = 5'b10000
  } state_e;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sample_s;

  typedef struct packed {
    logic [2:0] lanes;
    logic [9:0] addr;
    sample_s data;
  } buf_wr_s;
endpackage

// ===== rtl/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic in_ready_reg;
  logic out_valid_reg;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_reg;
  assign pop = out_valid_reg & out_ready_i;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o = in_ready_reg;
  assign out_valid_o = out_valid_reg;
  assign out_data_o = mem[rd_ptr_reg];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready_reg <= count_next != (AW+1)'(DEPTH);
      out_valid_reg <= count_next != '0;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/vibration_capture_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module vibration_capture_sequencer
  import vcs_pkg::*;
#(
  parameter int TICK_CYCLES = SEC_CYCLES,
  parameter int WAKE_RECOVERY_CYCLES = WAKE_CYCLES,
  parameter int FLASH_STORE_CYCLES = FLASH_CYCLES,
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Serial interface
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_din_i,
  output logic spi_dout_o,
  output logic spi_dout_oe_n_o,
  // Digital pins
  input wire logic pin_one_i,
  input wire logic pin_two_i,
  // Sample stream
  input wire sample_s sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // Capture buffer write port
  output var buf_wr_s buf_wr_o,
  output logic buf_wr_valid_o,
  input wire logic buf_ready_i,
  // Mirror, power and status
  output logic flash_store_o,
  output logic flash_restore_o,
  output logic sleep_o,
  output logic busy_o,
  output logic capture_done_o,
  output logic [AVG_W-1:0] avg_count_o
);
  // Pin synchronisers and edge history
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_n_s, din_s;
  logic pin_edge;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 5'h03;
      sync_reg <= 5'h03;
      prev_reg <= 5'h03;
    end else begin
      meta_reg <= {pin_two_i, pin_one_i, spi_din_i, spi_cs_n_i, spi_sclk_i};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic [15:0] capture_setup_reg;
  logic [15:0] capture_interval_reg;
  logic [15:0] alarm_thr_reg [3];
  logic [15:0] alarm_setup_reg;
  logic [15:0] pin_setup_reg;
  logic [15:0] avg_count_reg;

  assign cs_n_s = sync_reg[1];
  assign din_s = sync_reg[2];
  assign sclk_rise = sync_reg[0] & ~prev_reg[0];
  assign sclk_fall = ~sync_reg[0] & prev_reg[0];
  assign cs_fall = ~sync_reg[1] & prev_reg[1];
  assign cs_rise = sync_reg[1] & ~prev_reg[1];
  assign pin_edge =
    (pin_setup_reg[PIN_ONE_TRIG_BIT] & sync_reg[3] & ~prev_reg[3]) |
    (pin_setup_reg[PIN_TWO_TRIG_BIT] & sync_reg[4] & ~prev_reg[4]);

  // Serial frame engine
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [15:0] rd_data_reg;
  logic [4:0] bit_cnt_reg;
  logic frame_bad_reg;
  logic dout_reg;
  logic dout_oe_n_reg;
  logic asleep_reg;
  logic [31:0] rec_cnt_reg;
  logic rec_busy;
  logic frame_ok;

  assign rec_busy = rec_cnt_reg != '0;
  assign frame_ok = cs_rise & (bit_cnt_reg == 5'(FRAME_BITS)) & ~frame_bad_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      frame_bad_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 5'h00;
      tx_reg <= {rd_data_reg[14:0], 1'b0};
      dout_reg <= rd_data_reg[15];
      frame_bad_reg <= asleep_reg | rec_busy;
    end else if (!cs_n_s) begin
      if (sclk_rise) begin
        rx_reg <= {rx_reg[14:0], din_s};
        if (bit_cnt_reg != 5'h1f) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
      if (sclk_fall) begin
        dout_reg <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_oe_n_reg <= 1'b1;
    end else begin
      dout_oe_n_reg <= cs_n_s;
    end
  end

  // Register writes, byte wide
  logic wr_en;
  logic [5:0] wr_word;
  logic wr_hi;
  logic [7:0] wr_byte;
  logic cmd_wr, cmd_trigger, cmd_sleep, cmd_restore;

  assign wr_en = frame_ok & rx_reg[15];
  assign wr_word = rx_reg[14:9];
  assign wr_hi = rx_reg[8];
  assign wr_byte = rx_reg[7:0];
  assign cmd_wr = wr_en & (wr_word == ADDR_GLOBAL_COMMAND[6:1]);
  assign cmd_trigger = cmd_wr & wr_hi & wr_byte[CMD_TRIGGER_BIT - 8];
  assign cmd_sleep = cmd_wr & ~wr_hi & wr_byte[CMD_SLEEP_BIT];
  assign cmd_restore = cmd_wr & wr_hi & wr_byte[CMD_RESTORE_BIT - 8];

  function automatic logic [15:0] put_byte(input logic [15:0] old,
                                           input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_setup_reg <= CAPTURE_SETUP_RST;
      capture_interval_reg <= CAPTURE_INTERVAL_RST;
      alarm_thr_reg[0] <= ALARM_RST;
      alarm_thr_reg[1] <= ALARM_RST;
      alarm_thr_reg[2] <= ALARM_RST;
      alarm_setup_reg <= ALARM_RST;
      pin_setup_reg <= PIN_SETUP_RST;
      avg_count_reg <= AVG_COUNT_RST;
    end else if (wr_en) begin
      unique case (wr_word)
        ADDR_CAPTURE_SETUP[6:1]:
          capture_setup_reg <= put_byte(capture_setup_reg, wr_hi, wr_byte);
        ADDR_CAPTURE_INTERVAL[6:1]:
          capture_interval_reg <=
            put_byte(capture_interval_reg, wr_hi, wr_byte);
        ADDR_X_ALARM[6:1]:
          alarm_thr_reg[0] <= put_byte(alarm_thr_reg[0], wr_hi, wr_byte);
        ADDR_Y_ALARM[6:1]:
          alarm_thr_reg[1] <= put_byte(alarm_thr_reg[1], wr_hi, wr_byte);
        ADDR_Z_ALARM[6:1]:
          alarm_thr_reg[2] <= put_byte(alarm_thr_reg[2], wr_hi, wr_byte);
        ADDR_ALARM_SETUP[6:1]:
          alarm_setup_reg <= put_byte(alarm_setup_reg, wr_hi, wr_byte);
        ADDR_PIN_SETUP[6:1]:
          pin_setup_reg <= put_byte(pin_setup_reg, wr_hi, wr_byte);
        ADDR_AVG_COUNT[6:1]:
          avg_count_reg <= put_byte(avg_count_reg, wr_hi, wr_byte);
        default: ;
      endcase
    end
  end

  // Register reads, answered in the next frame
  state_e state_reg;
  logic [15:0] rd_mux;

  always_comb begin
    unique case (rx_reg[14:9])
      ADDR_CAPTURE_SETUP[6:1]: rd_mux = capture_setup_reg;
      ADDR_CAPTURE_INTERVAL[6:1]: rd_mux = capture_interval_reg;
      ADDR_X_ALARM[6:1]: rd_mux = alarm_thr_reg[0];
      ADDR_Y_ALARM[6:1]: rd_mux = alarm_thr_reg[1];
      ADDR_Z_ALARM[6:1]: rd_mux = alarm_thr_reg[2];
      ADDR_ALARM_SETUP[6:1]: rd_mux = alarm_setup_reg;
      ADDR_PIN_SETUP[6:1]: rd_mux = pin_setup_reg;
      ADDR_AVG_COUNT[6:1]: rd_mux = avg_count_reg;
      ADDR_STATUS[6:1]: rd_mux = {10'h000, rec_busy, state_reg};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= 16'h0000;
    end else if (frame_ok && !rx_reg[15]) begin
      rd_data_reg <= rd_mux;
    end
  end

  // Sample path and alarm checks
  sample_s fifo_data;
  logic fifo_valid;
  logic consume;
  logic [2:0] trip;
  logic trip_any;

  sample_fifo #(
    .WIDTH($bits(sample_s)),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(consume)
  );

  assign consume = fifo_valid & buf_ready_i &
                   (state_reg == ST_PRE || state_reg == ST_FILL);

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_alarm
      logic signed [16:0] s_v, t_v;
      assign s_v = 17'(signed'(fifo_data[47 - 16*ax -: 16]));
      assign t_v = 17'(signed'(alarm_thr_reg[ax]));
      assign trip[ax] = alarm_setup_reg[ax] &
                        ((s_v > t_v) || (s_v < -t_v));
    end
  endgenerate
  assign trip_any = |trip;

  // Capture sequencer
  mode_e mode;
  logic [11:0] idx_reg;
  logic [11:0] pre_len;
  logic [11:0] last_idx;
  logic [1:0] axis;
  logic [19:0] unit_secs;
  logic [19:0] period_secs;
  logic [19:0] secs_left_reg;
  logic [31:0] tick_cnt_reg;
  logic [31:0] flash_cnt_reg;
  logic tick, trigger, cap_end, flash_en, done_reg, flash_store_reg;

  assign mode = mode_e'(capture_setup_reg[SETUP_MODE_LSB +: 2]);
  assign pre_len = 12'(PRE_MIN) << capture_setup_reg[SETUP_PRE_LSB +: 2];
  assign last_idx = (mode == MODE_EXT) ? 12'(EXT_DEPTH - 1)
                                       : 12'(BUF_DEPTH - 1);
  assign axis = capture_setup_reg[SETUP_AXIS_LSB +: 2];
  assign flash_en = capture_setup_reg[SETUP_FLASH_BIT];
  assign trigger = cmd_trigger | (pin_edge & ~asleep_reg);
  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  assign cap_end = state_reg == ST_FILL && consume && idx_reg == last_idx &&
                   !trigger;

  always_comb begin
    unique case (capture_interval_reg[INTERVAL_UNIT_LSB +: 2])
      2'b01: unit_secs = 20'(SECS_PER_MIN);
      2'b10: unit_secs = 20'(SECS_PER_HOUR);
      default: unit_secs = 20'(SECOND_S);
    endcase
  end
  assign period_secs = 20'(20'(capture_interval_reg[7:0]) * unit_secs);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= 12'h000;
      secs_left_reg <= 20'h00000;
      tick_cnt_reg <= 32'h0;
      flash_cnt_reg <= 32'h0;
      done_reg <= 1'b0;
      flash_store_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      flash_store_reg <= 1'b0;
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      unique case (state_reg)
        ST_IDLE: if (trigger) begin
          idx_reg <= 12'h000;
          state_reg <= (mode == MODE_EVENT) ? ST_PRE : ST_FILL;
        end
        ST_PRE: if (trigger) begin
          state_reg <= ST_IDLE;
        end else if (consume) begin
          if (trip_any) begin
            idx_reg <= pre_len;
            state_reg <= ST_FILL;
          end else begin
            idx_reg <= (idx_reg + 12'h001) & (pre_len - 12'h001);
          end
        end
        ST_FILL: if (trigger) begin
          state_reg <= ST_IDLE;
        end else if (cap_end) begin
          if (flash_en) begin
            flash_store_reg <= 1'b1;
            flash_cnt_reg <= 32'(FLASH_STORE_CYCLES - 1);
            state_reg <= ST_FLASH;
          end else begin
            done_reg <= 1'b1;
            secs_left_reg <= period_secs;
            tick_cnt_reg <= 32'h0;
            state_reg <= (mode == MODE_AUTO) ? ST_COUNT : ST_IDLE;
          end
        end else if (consume) begin
          idx_reg <= idx_reg + 12'h001;
        end
        ST_FLASH: if (trigger) begin
          state_reg <= ST_IDLE;
        end else if (flash_cnt_reg == 32'h0) begin
          done_reg <= 1'b1;
          secs_left_reg <= period_secs;
          tick_cnt_reg <= 32'h0;
          state_reg <= (mode == MODE_AUTO) ? ST_COUNT : ST_IDLE;
        end else begin
          flash_cnt_reg <= flash_cnt_reg - 32'h1;
        end
        ST_COUNT: if (trigger || mode != MODE_AUTO) begin
          state_reg <= ST_IDLE;
        end else if (tick) begin
          if (secs_left_reg <= 20'h00001) begin
            idx_reg <= 12'h000;
            state_reg <= ST_FILL;
          end else begin
            secs_left_reg <= secs_left_reg - 20'h00001;
          end
        end
      endcase
    end
  end

  // Capture buffer writes
  buf_wr_s buf_wr_reg;
  logic buf_wr_valid_reg;
  logic ext_fill;

  assign ext_fill = mode == MODE_EXT && state_reg == ST_FILL;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_wr_reg <= '0;
      buf_wr_valid_reg <= 1'b0;
    end else begin
      buf_wr_valid_reg <= consume;
      if (consume) begin
        buf_wr_reg.addr <= idx_reg[9:0];
        if (ext_fill) begin
          buf_wr_reg.lanes <= 3'b001 << idx_reg[11:10];
          unique case (axis)
            2'b01: buf_wr_reg.data <= '{fifo_data.y, fifo_data.y, fifo_data.y};
            2'b10: buf_wr_reg.data <= '{fifo_data.z, fifo_data.z, fifo_data.z};
            default:
              buf_wr_reg.data <= '{fifo_data.x, fifo_data.x, fifo_data.x};
          endcase
        end else begin
          buf_wr_reg.lanes <= 3'b111;
          buf_wr_reg.data <= fifo_data;
        end
      end
    end
  end

  // Sleep, wake and recovery
  logic sleep_enter;
  logic count_expire;

  assign count_expire = state_reg == ST_COUNT && tick &&
                        secs_left_reg <= 20'h00001;
  assign sleep_enter = cmd_sleep | (done_reg & capture_setup_reg[SETUP_PD_BIT]);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asleep_reg <= 1'b0;
      rec_cnt_reg <= 32'h0;
    end else if (sleep_enter) begin
      asleep_reg <= 1'b1;
    end else if (asleep_reg && (cs_fall || pin_edge)) begin
      asleep_reg <= 1'b0;
      rec_cnt_reg <= 32'(WAKE_RECOVERY_CYCLES);
    end else if (asleep_reg && count_expire) begin
      asleep_reg <= 1'b0;
    end else if (rec_busy) begin
      rec_cnt_reg <= rec_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      flash_restore_o <= 1'b0;
    end else begin
      busy_o <= state_reg != ST_IDLE;
      flash_restore_o <= cmd_restore;
    end
  end

  assign spi_dout_o = dout_reg;
  assign spi_dout_oe_n_o = dout_oe_n_reg;
  assign buf_wr_o = buf_wr_reg;
  assign buf_wr_valid_o = buf_wr_valid_reg;
  assign flash_store_o = flash_store_reg;
  assign sleep_o = asleep_reg;
  assign capture_done_o = done_reg;
  assign avg_count_o = avg_count_reg[AVG_W-1:0];

  a_auto_rearm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cap_end && !flash_en && mode == MODE_AUTO |=> state_reg == ST_COUNT)
    else $error("automatic capture did not start countdown");
  a_unit_minutes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cap_end && !flash_en && mode == MODE_AUTO &&
    capture_interval_reg[9:8] == 2'b01 |=>
    secs_left_reg == 20'($past(capture_interval_reg[7:0]) * 20'd60))
    else $error("minute unit not applied");
  a_count_launch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    count_expire && !trigger && mode == MODE_AUTO |=>
    state_reg == ST_FILL && idx_reg == 12'h000)
    else $error("countdown expiry did not launch capture");
  a_pd_sleep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    done_reg && capture_setup_reg[SETUP_PD_BIT] |=> sleep_o)
    else $error("no sleep after capture");
  a_pre_window: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    consume && state_reg == ST_PRE |-> idx_reg < pre_len)
    else $error("pre-event index beyond window");
  a_trip_post: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == ST_PRE && consume && trip_any && !trigger |=>
    state_reg == ST_FILL && idx_reg == $past(pre_len))
    else $error("alarm did not start post-event fill");
  a_ext_lanes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    consume && ext_fill |=> buf_wr_valid_o &&
    buf_wr_o.lanes == (3'b001 << $past(idx_reg[11:10])))
    else $error("extended sample in wrong buffer");
  a_wake_cs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sleep_o && cs_fall && !sleep_enter |=> !sleep_o ##0 rec_busy)
    else $error("chip select did not wake device");
  a_sleep_cmd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_sleep |=> sleep_o)
    else $error("sleep command ignored");
  a_flash_copy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    flash_store_o |-> state_reg == ST_FLASH && flash_en && !capture_done_o)
    else $error("mirror store outside capture end");
endmodule
`default_nettype wire

// ===== bench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Link to device
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // One frame, MSB first; link clock stands high between frames
  // Read bit taken at the end of each high phase, before the fall shifts it
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      r[i] = dout_i;
      sclk_o = 1'b0;
      din_o = w[i];
      #24;
      sclk_o = 1'b1;
      #24;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o;
    #48;
  endtask
  // Wake pulse only, then re-frame after recovery
  task automatic wake();
    cs_n_o = 1'b0;
    #48;
    cs_n_o = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vcs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic buf_ready_i = 1'b1;
  logic sclk, cs_n, din, dout, sleep_o, busy_o, done, st, rs, wv, srdy;
  sample_s smp = {16'h1111, 16'h2222, 16'h3333};
  buf_wr_s wr, first, last;
  int n_fail = 0;
  int total_checks = 0;
  int n_wr, n_done, n_st, n_rs, cyc;
  int n_hi, lo_max, t_prev, t_last, gap;
  logic pin1 = 1'b0;
  localparam int TICK = 20;
  localparam int MIN_CYC = SECS_PER_MIN * TICK;
  logic [15:0] q;
  always #2.5 core_clk_i = ~core_clk_i;
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout));
  vibration_capture_sequencer #(.TICK_CYCLES(TICK), .WAKE_RECOVERY_CYCLES(50),
    .FLASH_STORE_CYCLES(10)) uut (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_n_o(),
    .pin_one_i(pin1), .pin_two_i(1'b0), .sample_i(smp),
    .sample_valid_i(1'b1), .sample_ready_o(srdy), .buf_wr_o(wr),
    .buf_wr_valid_o(wv), .buf_ready_i(buf_ready_i), .flash_store_o(st),
    .flash_restore_o(rs), .sleep_o(sleep_o), .busy_o(busy_o),
    .capture_done_o(done), .avg_count_o());
  always @(negedge core_clk_i) begin
    cyc++;
    buf_ready_i = (cyc % 4) != 0;
  end
  always @(negedge core_clk_i) begin
    if (wv === 1'b1) begin
      if (n_wr == 0) first = wr;
      last = wr;
      n_wr++;
      if (wr.data.x == 16'h2345) n_hi++;
      else if (int'(wr.addr) > lo_max) lo_max = int'(wr.addr);
    end
    if (done === 1'b1) begin
      t_prev = t_last;
      t_last = cyc;
      n_done++;
    end
    if (st === 1'b1) n_st++;
    if (rs === 1'b1) n_rs++;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, q);
  endtask
  task automatic rd(input logic [6:0] a);
    host.xfer({1'b0, a, 8'h00}, q);
    host.xfer(16'h0000, q);
  endtask
  task automatic clr();
    @(negedge core_clk_i);
    n_wr = 0;
    n_done = 0;
    n_st = 0;
    n_rs = 0;
    n_hi = 0;
    lo_max = 0;
  endtask
  task automatic wt(input int n);
    for (int i = 0; i < 8000 && n_done < n; i++) @(negedge core_clk_i);
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic go(input int n);
    clr();
    wb(7'h3f, 8'h08);
    wt(n);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_n_i = 1'b1;
    repeat (20) @(negedge core_clk_i);
    chk("fifo_ready", 16'h0, {15'h0, srdy});
    rd(ADDR_CAPTURE_INTERVAL);
    chk("intv_rst", CAPTURE_INTERVAL_RST, q);
    wb(ADDR_CAPTURE_INTERVAL, 8'h02);
    rd(ADDR_CAPTURE_INTERVAL);
    chk("intv", 16'h0002, q);
    wb(7'h1d, 8'h02);
    wb(ADDR_CAPTURE_SETUP, 8'h0c);
    go(1);
    chk("ext_n", 16'(EXT_DEPTH), 16'(n_wr));
    chk("ext_first", 16'h1, 16'(first.lanes));
    chk("ext_last", 16'h4, 16'(last.lanes));
    chk("ext_axis", 16'h3333, first.data.x);
    wb(ADDR_CAPTURE_SETUP, 8'h42);
    go(1);
    chk("man_n", 16'(BUF_DEPTH), 16'(n_wr));
    chk("store", 16'h1, 16'(n_st));
    chk("pd_sleep", 16'h1, {15'h0, sleep_o});
    host.wake();
    chk("woken", 16'h0, {15'h0, sleep_o});
    wb(7'h3f, 8'h20);
    chk("restore", 16'h1, 16'(n_rs));
    wb(ADDR_PIN_SETUP, 8'h01);
    wb(ADDR_GLOBAL_COMMAND, 8'h02);
    chk("sleep_cmd", 16'h1, {15'h0, sleep_o});
    @(negedge core_clk_i) pin1 = 1'b1;
    repeat (60) @(negedge core_clk_i);
    chk("pin_wake", 16'h0, {15'h0, sleep_o});
    pin1 = 1'b0;
    wb(7'h1f, 8'h01);
    wb(ADDR_CAPTURE_INTERVAL, 8'h01);
    wb(ADDR_CAPTURE_SETUP, 8'h04);
    go(2);
    chk("auto_rep", 16'h2, 16'(n_done));
    gap = t_last - t_prev;
    chk("gap_lo", 16'h1, 16'(gap > MIN_CYC + BUF_DEPTH));
    chk("gap_hi", 16'h1, 16'(gap < MIN_CYC + 2 * BUF_DEPTH));
    wb(7'h3f, 8'h08);
    repeat (4) @(negedge core_clk_i);
    chk("auto_stop", 16'h0, {15'h0, busy_o});
    wb(7'h21, 8'h20);
    wb(ADDR_ALARM_SETUP, 8'h01);
    wb(ADDR_CAPTURE_SETUP, 8'h18);
    clr();
    wb(7'h3f, 8'h08);
    repeat (400) @(negedge core_clk_i);
    smp.x = 16'h2345;
    wt(1);
    chk("pre_wrap", 16'h7f, 16'(lo_max));
    chk("post_n", 16'(BUF_DEPTH - 128 + 1), 16'(n_hi));
    chk("post_end", 16'h3ff, 16'(last.addr));
    summarize();
  end
endmodule
`default_nettype wire
